// >>> lrra_consts.svh
// Constants for the long read and block reassign command interpreter
`ifndef LRRA_CONSTS_SVH
`define LRRA_CONSTS_SVH
`define OPC_LONG_READ      8'h3e
`define OPC_REASSIGN       8'h07
`define CDB_LEN_LONG_READ  4'ha
`define CDB_LEN_REASSIGN   4'h6
`define CDB_BIT_ECC        1
`define CDB_BIT_RELATIVE_ADDRESS_FLAG     0
`define HDR_LEN            2'h3
`define DESC_LAST          2'h3
`define KEY_NONE           4'h0
`define KEY_MEDIUM         4'h3
`define KEY_HARDWARE       4'h4
`define KEY_ILLEGAL        4'h5
`define ASC_NONE           8'h00
`define ASC_UNREC_READ     8'h11
`define ASC_BAD_OPCODE     8'h20
`define ASC_BAD_CDB_FIELD  8'h24
`define ASC_NO_SPARE       8'h32
`define CSI_NONE           32'h0fffffff
`endif

// >>> lrra_pkg.sv
// Types for the long read and block reassign command interpreter
package lrra_pkg;
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_CDB     = 4'h1,
    ST_DECODE  = 4'h2,
    ST_RL_WAIT = 4'h3,
    ST_RL_XFER = 4'h4,
    ST_RA_HDR  = 4'h5,
    ST_RA_DESC = 4'h6,
    ST_RA_WAIT = 4'h7
  } state_type;

  typedef struct packed {
    logic        valid;
    logic        incorrect_length_flag;
    logic [3:0]  key;
    logic [7:0]  asc;
    logic [31:0] info;
    logic [31:0] csi;
  } sense_type;

  typedef struct packed {
    state_type   st;
    logic [3:0]  idx;
    logic [3:0]  cdb_len;
    logic [79:0] cdb;
    logic [15:0] cnt;
    logic [15:0] list_left;
    logic [1:0]  bidx;
    logic [31:0] lba;
    logic        med_req;
    logic        remap_req;
    logic        glist_add;
    logic        data_valid;
    logic [7:0]  data_byte;
    logic        done;
    logic        check;
    sense_type   sense;
  } core_type;
endpackage

// >>> lrra_core.sv
// Long read and block reassign command interpreter, target side
`timescale 1ns/10ps
`include "lrra_consts.svh"

module lrra_core (
  input  wire logic              i_clock,             // 200 MHz clock
  input  wire logic              i_rst_n,             // Async reset, active low
  input  wire logic              i_cdb_valid,         // Descriptor byte strobe
  input  wire logic [7:0]        i_cdb_byte,          // Descriptor byte
  output logic                   o_med_req,           // Long read medium request pulse
  output logic [31:0]            o_med_lba,           // Block address for medium
  output logic                   o_ecc_correct_flag,  // Medium applies ECC correction
  output logic                   o_relative_address_flag, // Address is relative
  input  wire logic              i_med_ack,           // Medium answers request
  input  wire logic [15:0]       i_med_avail_len,     // Data plus ECC bytes available
  output logic                   o_med_xfer,          // Medium may stream bytes
  input  wire logic              i_med_valid,         // Medium byte strobe
  input  wire logic [7:0]        i_med_byte,          // Medium byte
  output logic                   o_data_valid,        // Byte to initiator strobe
  output logic [7:0]             o_data_byte,         // Byte to initiator
  input  wire logic              i_param_valid,       // Defect list byte strobe
  input  wire logic [7:0]        i_param_byte,        // Defect list byte
  output logic                   o_param_ready,       // Defect list byte accepted
  output logic                   o_remap_req,         // Remap request pulse
  output logic [31:0]            o_remap_lba,         // Block to remap
  input  wire logic              i_remap_ack,         // Remap finished
  input  wire logic              i_spare_empty,       // No spare location left
  input  wire logic              i_unrec_err,         // Unrecoverable read elsewhere
  input  wire logic [31:0]       i_unrec_lba,         // Address of that block
  input  wire logic              i_glist_supported,   // Grown list exists
  output logic                   o_glist_add,         // Record remapped block pulse
  output logic                   o_done,              // Command complete pulse
  output logic                   o_check,             // Check condition with o_done
  output lrra_pkg::sense_type    o_sense              // Sense data, held to next command
);
  logic rst_meta_reg;
  logic rst_sync_reg;
  lrra_pkg::core_type s_reg;
  lrra_pkg::core_type s_next;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  logic [7:0]  opcode;
  logic [15:0] req_len;
  logic [31:0] cdb_lba;
  logic [31:0] desc_lba;
  assign opcode   = s_reg.cdb[79:72];
  assign cdb_lba  = s_reg.cdb[63:32];
  assign req_len  = s_reg.cdb[15:0] >> 8 | {s_reg.cdb[23:16], 8'h00};
  assign desc_lba = {s_reg.lba[23:0], i_param_byte};

  always_comb begin
    s_next = s_reg;
    s_next.med_req    = 1'b0;
    s_next.remap_req  = 1'b0;
    s_next.glist_add  = 1'b0;
    s_next.data_valid = 1'b0;
    s_next.done       = 1'b0;
    case (s_reg.st)
      lrra_pkg::ST_IDLE: begin
        if (i_cdb_valid) begin
          s_next.cdb = {i_cdb_byte, 72'h0};
          s_next.idx = 4'h1;
          s_next.check = 1'b0;
          s_next.sense = '{1'b0, 1'b0, `KEY_NONE, `ASC_NONE, 32'h0, `CSI_NONE};
          if (i_cdb_byte == `OPC_LONG_READ) begin
            s_next.cdb_len = `CDB_LEN_LONG_READ;
            s_next.st = lrra_pkg::ST_CDB;
          end else if (i_cdb_byte == `OPC_REASSIGN) begin
            s_next.cdb_len = `CDB_LEN_REASSIGN;
            s_next.st = lrra_pkg::ST_CDB;
          end else begin
            s_next.check = 1'b1;
            s_next.done = 1'b1;
            s_next.sense.key = `KEY_ILLEGAL;
            s_next.sense.asc = `ASC_BAD_OPCODE;
          end
        end
      end
      lrra_pkg::ST_CDB: begin
        if (i_cdb_valid) begin
          s_next.cdb[79 - 8 * s_reg.idx -: 8] = i_cdb_byte;
          s_next.idx = s_reg.idx + 4'h1;
          if (s_reg.idx + 4'h1 == s_reg.cdb_len) begin
            s_next.st = lrra_pkg::ST_DECODE;
          end
        end
      end
      lrra_pkg::ST_DECODE: begin
        if (opcode == `OPC_LONG_READ) begin
          s_next.lba = cdb_lba;
          s_next.cnt = req_len;
          s_next.med_req = 1'b1;
          s_next.st = lrra_pkg::ST_RL_WAIT;
        end else begin
          s_next.idx = 4'h0;
          s_next.st = lrra_pkg::ST_RA_HDR;
        end
      end
      lrra_pkg::ST_RL_WAIT: begin
        if (i_med_ack) begin
          if (s_reg.cnt == 16'h0) begin
            s_next.done = 1'b1;
            s_next.st = lrra_pkg::ST_IDLE;
          end else if (s_reg.cnt != i_med_avail_len) begin
            s_next.done = 1'b1;
            s_next.check = 1'b1;
            s_next.sense.key = `KEY_ILLEGAL;
            s_next.sense.asc = `ASC_BAD_CDB_FIELD;
            s_next.sense.valid = 1'b1;
            s_next.sense.incorrect_length_flag = 1'b1;
            s_next.sense.info = {16'h0, s_reg.cnt} - {16'h0, i_med_avail_len};
            s_next.st = lrra_pkg::ST_IDLE;
          end else begin
            s_next.st = lrra_pkg::ST_RL_XFER;
          end
        end
      end
      lrra_pkg::ST_RL_XFER: begin
        if (i_med_valid) begin
          s_next.data_valid = 1'b1;
          s_next.data_byte = i_med_byte;
          s_next.cnt = s_reg.cnt - 16'h1;
          if (s_reg.cnt == 16'h1) begin
            s_next.done = 1'b1;
            s_next.st = lrra_pkg::ST_IDLE;
          end
        end
      end
      lrra_pkg::ST_RA_HDR: begin
        if (i_param_valid) begin
          s_next.list_left = {s_reg.list_left[7:0], i_param_byte};
          s_next.idx = s_reg.idx + 4'h1;
          s_next.bidx = 2'h0;
          if (s_reg.idx[1:0] == `HDR_LEN) begin
            if ({s_reg.list_left[7:0], i_param_byte} < 16'h4) begin
              s_next.done = 1'b1;
              s_next.st = lrra_pkg::ST_IDLE;
            end else begin
              s_next.st = lrra_pkg::ST_RA_DESC;
            end
          end
        end
      end
      lrra_pkg::ST_RA_DESC: begin
        if (i_param_valid) begin
          s_next.lba = desc_lba;
          s_next.bidx = s_reg.bidx + 2'h1;
          s_next.list_left = s_reg.list_left - 16'h1;
          if (s_reg.bidx == `DESC_LAST) begin
            s_next.remap_req = 1'b1;
            s_next.st = lrra_pkg::ST_RA_WAIT;
          end
        end
      end
      lrra_pkg::ST_RA_WAIT: begin
        if (i_remap_ack) begin
          if (i_spare_empty) begin
            s_next.done = 1'b1;
            s_next.check = 1'b1;
            s_next.sense.key = `KEY_HARDWARE;
            s_next.sense.asc = `ASC_NO_SPARE;
            s_next.sense.csi = s_reg.lba;
            s_next.st = lrra_pkg::ST_IDLE;
          end else if (i_unrec_err) begin
            s_next.done = 1'b1;
            s_next.check = 1'b1;
            s_next.sense.key = `KEY_MEDIUM;
            s_next.sense.asc = `ASC_UNREC_READ;
            s_next.sense.valid = 1'b1;
            s_next.sense.info = i_unrec_lba;
            s_next.sense.csi = s_reg.lba;
            s_next.st = lrra_pkg::ST_IDLE;
          end else begin
            s_next.glist_add = i_glist_supported;
            if (s_reg.list_left < 16'h4) begin
              s_next.done = 1'b1;
              s_next.st = lrra_pkg::ST_IDLE;
            end else begin
              s_next.st = lrra_pkg::ST_RA_DESC;
            end
          end
        end
      end
      default: begin
        s_next.st = lrra_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_med_req               = s_reg.med_req;
  assign o_med_lba               = s_reg.lba;
  assign o_ecc_correct_flag      = s_reg.cdb[64 + `CDB_BIT_ECC];
  assign o_relative_address_flag = s_reg.cdb[64 + `CDB_BIT_RELATIVE_ADDRESS_FLAG];
  assign o_med_xfer              = (s_reg.st == lrra_pkg::ST_RL_XFER);
  assign o_data_valid            = s_reg.data_valid;
  assign o_data_byte             = s_reg.data_byte;
  assign o_param_ready           = (s_reg.st == lrra_pkg::ST_RA_HDR) ||
                                   (s_reg.st == lrra_pkg::ST_RA_DESC);
  assign o_remap_req             = s_reg.remap_req;
  assign o_remap_lba             = s_reg.lba;
  assign o_glist_add             = s_reg.glist_add;
  assign o_done                  = s_reg.done;
  assign o_check                 = s_reg.check;
  assign o_sense                 = s_reg.sense;

  a_zero_len_good: assert property (@(posedge i_clock) disable iff (!rst_sync_reg)
    s_reg.st == lrra_pkg::ST_RL_WAIT && i_med_ack && s_reg.cnt == 16'h0
    |=> o_done && !o_check && !o_data_valid) else $error("zero length long read failed");
  a_len_mismatch: assert property (@(posedge i_clock) disable iff (!rst_sync_reg)
    s_reg.st == lrra_pkg::ST_RL_WAIT && i_med_ack && s_reg.cnt != 16'h0 &&
    s_reg.cnt != i_med_avail_len
    |=> o_done && o_check && o_sense.key == 4'h5 && o_sense.asc == 8'h24)
    else $error("length mismatch not reported");
  a_residue_value: assert property (@(posedge i_clock) disable iff (!rst_sync_reg)
    s_reg.st == lrra_pkg::ST_RL_WAIT && i_med_ack && s_reg.cnt != 16'h0 &&
    s_reg.cnt != i_med_avail_len
    |=> o_sense.valid && o_sense.incorrect_length_flag &&
        o_sense.info == 32'({16'h0, $past(s_reg.cnt)} - {16'h0, $past(i_med_avail_len)}))
    else $error("bad residue");
  a_ecc_to_medium: assert property (@(posedge i_clock) disable iff (!rst_sync_reg)
    o_med_req |-> $past(s_reg.st) == lrra_pkg::ST_DECODE && $past(opcode) == 8'h3e &&
    o_ecc_correct_flag == s_reg.cdb[65] &&
    o_med_lba == cdb_lba) else $error("ecc flag or address wrong");
  a_xfer_only: assert property (@(posedge i_clock) disable iff (!rst_sync_reg)
    o_data_valid |-> $past(o_med_xfer) && $past(i_med_valid) &&
    o_data_byte == $past(i_med_byte)) else $error("stray data byte");
  a_no_spare: assert property (@(posedge i_clock) disable iff (!rst_sync_reg)
    s_reg.st == lrra_pkg::ST_RA_WAIT && i_remap_ack && i_spare_empty
    |=> o_done && o_check && o_sense.key == 4'h4 && o_sense.asc == 8'h32 &&
        o_sense.csi == $past(o_remap_lba)) else $error("spare error not reported");
  a_unrec_info: assert property (@(posedge i_clock) disable iff (!rst_sync_reg)
    s_reg.st == lrra_pkg::ST_RA_WAIT && i_remap_ack && !i_spare_empty && i_unrec_err
    |=> o_check && o_sense.valid && o_sense.info == $past(i_unrec_lba))
    else $error("unrecoverable block not reported");
  a_glist_record: assert property (@(posedge i_clock) disable iff (!rst_sync_reg)
    s_reg.st == lrra_pkg::ST_RA_WAIT && i_remap_ack && !i_spare_empty && !i_unrec_err
    |=> o_glist_add == $past(i_glist_supported)) else $error("grown list not updated");
  a_good_csi: assert property (@(posedge i_clock) disable iff (!rst_sync_reg)
    o_done && !o_check |-> o_sense.csi == 32'h0fffffff) else $error("csi not cleared");
  a_remap_after_4: assert property (@(posedge i_clock) disable iff (!rst_sync_reg)
    o_remap_req |-> $past(o_param_ready) && $past(i_param_valid) &&
    o_remap_lba[7:0] == $past(i_param_byte)) else $error("descriptor mis-assembled");
endmodule

// >>> lrra_backend_model.sv
// Medium and spare-area responder facing the command interpreter
`timescale 1ns/10ps
module lrra_backend_model (
  input  wire logic        i_clock,       // Clock
  input  wire logic        i_med_req,     // Read request
  input  wire logic        i_med_xfer,    // Stream enable
  input  wire logic        i_remap_req,   // Remap request
  input  wire logic [31:0] i_remap_lba,   // Block to remap
  input  wire logic [15:0] i_avail,       // Bytes held for the block
  input  wire logic [31:0] i_spare_lim,   // First block with no spare
  input  wire logic [31:0] i_bad_at,      // Remap that hits a read error
  output logic             o_med_ack,     // Read answer
  output logic             o_med_valid,   // Byte strobe
  output logic [7:0]       o_med_byte,    // Byte
  output logic             o_remap_ack,   // Remap answer
  output logic             o_spare_empty, // No spare left
  output logic             o_unrec_err    // Read error elsewhere
);
  logic [15:0] sent = 16'h0000;
  logic        pend = 1'b0;
  initial begin
    {o_med_ack, o_med_valid, o_remap_ack, o_spare_empty, o_unrec_err} = 5'h00;
    o_med_byte = 8'h00;
  end
  always @(posedge i_clock) begin
    o_med_ack <= i_med_req;
    if (i_med_req) sent <= 16'h0000;
    if (i_med_xfer && sent < i_avail) begin
      o_med_valid <= 1'b1;
      o_med_byte  <= sent[7:0] ^ 8'h5a;
      sent        <= sent + 16'h0001;
    end else begin
      // Idle bus inverts the last byte on every idle cycle
      o_med_valid <= 1'b0;
      o_med_byte  <= ~o_med_byte;
    end
    pend          <= i_remap_req;
    o_remap_ack   <= pend;
    o_spare_empty <= pend && i_remap_lba >= i_spare_lim;
    o_unrec_err   <= pend && i_remap_lba == i_bad_at;
  end
endmodule

// >>> testbench.sv
// Self-checking bench for the long read and block reassign interpreter
`timescale 1ns/10ps
module testbench;
  logic        i_clock = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_cdb_valid = 1'b0;
  logic [7:0]  i_cdb_byte = 8'h00;
  logic        i_param_valid = 1'b0;
  logic [7:0]  i_param_byte = 8'h00;
  logic        glist = 1'b0;
  logic [15:0] avail = 16'h0000;
  logic [31:0] spare_lim = 32'hffffffff;
  logic [31:0] bad_at = 32'hffffffff;
  logic        med_req, med_xfer, med_ack, med_valid, remap_req, remap_ack;
  logic        spare_empty, unrec_err, data_valid, glist_add, done, check;
  logic        ecc, rel, param_ready, seen_done, got_check, got_ecc, got_rel;
  logic [7:0]  med_byte, data_byte;
  logic [31:0] med_lba, remap_lba, got_lba;
  lrra_pkg::sense_type sense, got_sense;
  logic [7:0]  got[$];
  logic [31:0] rm[$];
  int          n_gl, n_mismatch, total_checks;
  always #2.5 i_clock = ~i_clock;
  lrra_core uut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_cdb_valid(i_cdb_valid),
    .i_cdb_byte(i_cdb_byte), .o_med_req(med_req), .o_med_lba(med_lba),
    .o_ecc_correct_flag(ecc), .o_relative_address_flag(rel), .i_med_ack(med_ack),
    .i_med_avail_len(avail), .o_med_xfer(med_xfer), .i_med_valid(med_valid),
    .i_med_byte(med_byte), .o_data_valid(data_valid), .o_data_byte(data_byte),
    .i_param_valid(i_param_valid), .i_param_byte(i_param_byte),
    .o_param_ready(param_ready), .o_remap_req(remap_req), .o_remap_lba(remap_lba),
    .i_remap_ack(remap_ack), .i_spare_empty(spare_empty), .i_unrec_err(unrec_err),
    .i_unrec_lba(32'h00000777), .i_glist_supported(glist), .o_glist_add(glist_add),
    .o_done(done), .o_check(check), .o_sense(sense));
  lrra_backend_model far_end (
    .i_clock(i_clock), .i_med_req(med_req), .i_med_xfer(med_xfer),
    .i_remap_req(remap_req), .i_remap_lba(remap_lba), .i_avail(avail),
    .i_spare_lim(spare_lim), .i_bad_at(bad_at), .o_med_ack(med_ack),
    .o_med_valid(med_valid), .o_med_byte(med_byte), .o_remap_ack(remap_ack),
    .o_spare_empty(spare_empty), .o_unrec_err(unrec_err));
  // Collects what the interpreter sends out
  always @(posedge i_clock) begin
    if (data_valid === 1'b1) got.push_back(data_byte);
    if (remap_req === 1'b1) rm.push_back(remap_lba);
    if (glist_add === 1'b1) n_gl++;
    if (med_req === 1'b1) begin
      got_lba = med_lba;
      got_ecc = ecc;
      got_rel = rel;
    end
    if (done === 1'b1) begin
      seen_done = 1'b1;
      got_check = check;
      got_sense = sense;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic put_cdb(input logic [7:0] b);
    @(posedge i_clock);
    #1 i_cdb_valid = 1'b1;
    i_cdb_byte = b;
  endtask
  task automatic start_cmd(input logic [7:0] b);
    got.delete();
    rm.delete();
    n_gl = 0;
    seen_done = 1'b0;
    put_cdb(b);
  endtask
  task automatic put_par(input logic [7:0] b);
    logic taken;
    taken = 1'b0;
    i_param_valid = 1'b1;
    i_param_byte = b;
    repeat (100) begin
      @(posedge i_clock);
      if (param_ready === 1'b1) begin
        taken = 1'b1;
        break;
      end
    end
    // Byte never accepted counts as a mismatch
    if (taken !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, taken, 1'b1);
    end
    #1;
  endtask
  task automatic wait_done;
    @(posedge i_clock);
    #1 i_cdb_valid = 1'b0;
    repeat (400) begin
      if (seen_done === 1'b1) break;
      @(posedge i_clock);
    end
    chk(seen_done, 1'b1);
    @(posedge i_clock);
    #1;
  endtask
  task automatic read_long(input logic e, input logic [15:0] len, input logic [15:0] av);
    avail = av;
    start_cmd(8'h3e);
    put_cdb({6'h00, e, ~e});
    put_cdb(8'h12);
    put_cdb(8'h34);
    put_cdb(8'h56);
    put_cdb(8'h78);
    put_cdb(8'h00);
    put_cdb(len[15:8]);
    put_cdb(len[7:0]);
    put_cdb(8'h00);
    wait_done;
  endtask
  task automatic reassign(input logic [31:0] a0, input logic [31:0] a1);
    start_cmd(8'h07);
    repeat (5) put_cdb(8'h00);
    @(posedge i_clock);
    #1 i_cdb_valid = 1'b0;
    put_par(8'h00);
    put_par(8'h00);
    put_par(8'h00);
    put_par(8'h08);
    for (int k = 24; k >= 0; k -= 8) put_par(a0[k+:8]);
    for (int k = 24; k >= 0; k -= 8) put_par(a1[k+:8]);
    i_param_valid = 1'b0;
    wait_done;
  endtask
  task automatic test_rl_good;
    read_long(1'b1, 16'h0008, 16'h0008);
    chk(got_lba, 32'h12345678);
    chk(got_ecc, 1'b1);
    chk(got_rel, 1'b0);
    chk(got.size(), 8);
    for (int k = 0; k < 8; k++) chk(got[k], k[7:0] ^ 8'h5a);
    chk(got_check, 1'b0);
    $display("test_rl_good done");
  endtask
  task automatic test_rl_short;
    read_long(1'b0, 16'h0006, 16'h0008);
    chk(got_ecc, 1'b0);
    chk(got_rel, 1'b1);
    chk(got_check, 1'b1);
    chk(got_sense.key, 4'h5);
    chk(got_sense.asc, 8'h24);
    chk({got_sense.valid, got_sense.incorrect_length_flag}, 2'h3);
    chk(got_sense.info, 32'hfffffffe);
    chk(got.size(), 0);
    $display("test_rl_short done");
  endtask
  task automatic test_rl_zero;
    read_long(1'b0, 16'h0000, 16'h0008);
    chk(got_check, 1'b0);
    chk(got.size(), 0);
    $display("test_rl_zero done");
  endtask
  task automatic test_ra_good;
    glist = 1'b1;
    for (int p = 0; p < 2; p++) begin
      reassign(32'h00000100, 32'h00000200);
      chk(rm.size(), 2);
      chk(rm[0], 32'h00000100);
      chk(rm[1], 32'h00000200);
      chk(n_gl, 2);
      chk(got_check, 1'b0);
    end
    $display("test_ra_good done");
  endtask
  task automatic test_ra_fail;
    glist = 1'b0;
    spare_lim = 32'h00000200;
    reassign(32'h00000100, 32'h00000200);
    chk(n_gl, 0);
    chk(got_check, 1'b1);
    chk({got_sense.key, got_sense.asc}, 12'h432);
    chk(got_sense.csi, 32'h00000200);
    spare_lim = 32'hffffffff;
    bad_at = 32'h00000200;
    reassign(32'h00000100, 32'h00000200);
    chk({got_sense.key, got_sense.asc}, 12'h311);
    chk(got_sense.valid, 1'b1);
    chk(got_sense.info, 32'h00000777);
    chk(got_sense.csi, 32'h00000200);
    bad_at = 32'hffffffff;
    // Reissue from the failed descriptor with the new bad block added
    reassign(got_sense.csi, got_sense.info);
    chk(rm.size(), 2);
    chk(rm[0], 32'h00000200);
    chk(rm[1], 32'h00000777);
    chk(got_check, 1'b0);
    chk(got_sense.csi, 32'h0fffffff);
    $display("test_ra_fail done");
  endtask
  task automatic test_bad_op;
    start_cmd(8'h99);
    wait_done;
    chk(got_check, 1'b1);
    chk({got_sense.key, got_sense.asc}, 12'h520);
    $display("test_bad_op done");
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_clock);
    #1 i_rst_n = 1'b1;
    repeat (3) @(posedge i_clock);
    #1;
    test_rl_good;
    test_rl_short;
    test_rl_zero;
    test_ra_good;
    test_ra_fail;
    test_bad_op;
    finish_test;
  end
  initial begin
    #100000;
    n_mismatch++;
    finish_test;
  end
endmodule
